// ===== src/lss_fifo.v
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module lss_fifo #(
    parameter WIDTH = 25,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // clock and reset
    input  wire             core_clk,
    input  wire             rstn,
    // write side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // read side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW:0]      count_reg;
    wire            do_wr;
    wire            do_rd;
    integer         i;

    assign in_ready  = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data  = mem_reg[rd_ptr_reg];
    assign do_wr     = in_valid && in_ready;
    assign do_rd     = out_valid && out_ready;

    // pointers, count and storage
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_reg[i] <= {WIDTH{1'b0}};
            end
        end else begin
            if (do_wr) begin
                mem_reg[wr_ptr_reg] <= in_data;
                wr_ptr_reg          <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ?
                                       {AW{1'b0}} : wr_ptr_reg + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ?
                              {AW{1'b0}} : rd_ptr_reg + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count_reg <= count_reg + 1'b1;
            end else if (do_rd && !do_wr) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== src/lss_regs.vh
// constants for the led sink shift, latch and blanking gate
`ifndef LSS_REGS_VH
`define LSS_REGS_VH
`define LSS_SHIFT_W     25
`define LSS_SINK_W      24
`define LSS_GROUP_W     8
`define LSS_SCALE_W     7
`define LSS_SEL_BIT     24
`define LSS_SCALE_RST   7'h7f
`define LSS_FIFO_DEPTH  8
`define LSS_REST_CYC    3'h3
`define LSS_CLK_NS      25
`define LSS_LINK_NS     200
`endif

// ===== src/lss_sync.v
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module lss_sync (
    // clock and reset
    input  wire core_clk,
    input  wire rstn,
    // level in and out
    input  wire din,
    output reg  dout
);
    reg meta_reg;
    // first stage feeds only the second
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= 1'b0;
            dout     <= 1'b0;
        end else begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// ===== src/lss_top.v
// serial shift register, output latch and blanking gate for 24 sinks
//
// What this block does
// - each shift clock rise captures the serial input into the register lsb
// - each shift clock rise moves held bits one place toward the msb
// - the shift register is 25 bits, fed serially from the input line
// - serial output shows the register msb, updated at shift clock rise
// - latch strobe rising edge copies the register into the on/off latch when its bit 24 is low and the latch fifo is not full
// - blanking high forces all 24 sinks off
// - blanking low drives each sink from its on/off latch bit
// - three groups of eight sinks, red green blue, each gated alike
// - a latch bit of one turns its sink on, zero turns it off
// - each group holds a 7-bit scale value, loaded when a latched word has bit 24 set
`timescale 1ns/1ps
`default_nettype none
`include "lss_regs.vh"
module lss_top #(
    parameter SHIFT_W = `LSS_SHIFT_W,
    parameter GROUP_W = `LSS_GROUP_W,
    parameter SCALE_W = `LSS_SCALE_W
) (
    // clock and reset
    input  wire               core_clk,
    input  wire               rstn,
    // serial link pins
    input  wire               shift_clk,
    input  wire               serial_in_line,
    input  wire               latch_strobe,
    input  wire               blank_in,
    output reg                serial_out_line,
    // sink controls
    output reg  [GROUP_W-1:0] red_sinks,
    output reg  [GROUP_W-1:0] green_sinks,
    output reg  [GROUP_W-1:0] blue_sinks,
    // group current scale values
    output reg  [SCALE_W-1:0] red_scale,
    output reg  [SCALE_W-1:0] green_scale,
    output reg  [SCALE_W-1:0] blue_scale,
    // latch fifo back-pressure
    output reg                latch_overrun
);
    localparam SINK_W = 3 * GROUP_W;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    wire sclk_s;
    wire ser_s;
    wire stb_s;
    wire blank_s;

    // shift clock and data pass equal depth, so they stay aligned
    lss_sync u_sync_sclk (
        .core_clk (core_clk),
        .rstn     (rstn),
        .din      (shift_clk),
        .dout     (sclk_s)
    );
    lss_sync u_sync_ser (
        .core_clk (core_clk),
        .rstn     (rstn),
        .din      (serial_in_line),
        .dout     (ser_s)
    );
    lss_sync u_sync_stb (
        .core_clk (core_clk),
        .rstn     (rstn),
        .din      (latch_strobe),
        .dout     (stb_s)
    );
    lss_sync u_sync_blank (
        .core_clk (core_clk),
        .rstn     (rstn),
        .din      (blank_in),
        .dout     (blank_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // edge detection on synchronised shift clock and strobe
    reg  sclk_d_reg;
    reg  stb_d_reg;
    wire sclk_rise;
    wire stb_rise;

    assign sclk_rise = sclk_s && !sclk_d_reg;
    assign stb_rise  = stb_s && !stb_d_reg;

    // delays reset low, the idle level of both pins, so no false edge
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sclk_d_reg <= 1'b0;
            stb_d_reg  <= 1'b0;
        end else begin
            sclk_d_reg <= sclk_s;
            stb_d_reg  <= stb_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // common shift register
    reg  [SHIFT_W-1:0] shift_reg;
    wire [SHIFT_W-1:0] shift_next;

    // data aligned with the clock by equal sync depth, sampled at its rise
    assign shift_next = {shift_reg[SHIFT_W-2:0], ser_s};

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            shift_reg       <= {SHIFT_W{1'b0}};
            serial_out_line <= 1'b0;
        end else if (sclk_rise) begin
            shift_reg       <= shift_next;
            serial_out_line <= shift_next[SHIFT_W-1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // latch fifo: each strobe snapshot queues for the latch stage unless the fifo is full
    wire               fifo_in_ready;
    wire               fifo_out_valid;
    wire [SHIFT_W-1:0] fifo_out_data;
    reg                apply_ready_reg;

    lss_fifo #(
        .WIDTH (SHIFT_W),
        .DEPTH (`LSS_FIFO_DEPTH),
        .AW    (3)
    ) u_fifo (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .in_valid  (stb_rise),
        .in_ready  (fifo_in_ready),
        .in_data   (shift_reg),
        .out_valid (fifo_out_valid),
        .out_ready (apply_ready_reg),
        .out_data  (fifo_out_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // latch stage state machine: idle, apply one entry, then rest
    localparam ST_IDLE  = 3'b001;
    localparam ST_APPLY = 3'b010;
    localparam ST_REST  = 3'b100;

    reg [2:0]         state_reg;
    reg [2:0]         state_next;
    reg [2:0]         rest_cnt_reg;
    reg [SINK_W-1:0]  onoff_reg;
    reg [SCALE_W-1:0] scale_r_reg;
    reg [SCALE_W-1:0] scale_g_reg;
    reg [SCALE_W-1:0] scale_b_reg;

    // apply one word, then rest: the drain is slower than the fastest strobe
    // train, so a burst can fill the fifo and the overrun pulse is reachable
    always @* begin
        case (state_reg)
            ST_IDLE:  state_next = fifo_out_valid ? ST_APPLY : ST_IDLE;
            ST_APPLY: state_next = ST_REST;
            ST_REST:  state_next = (rest_cnt_reg == 3'h0) ? ST_IDLE : ST_REST;
            default:  state_next = ST_IDLE;
        endcase
    end

    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg       <= ST_IDLE;
            rest_cnt_reg    <= 3'h0;
            apply_ready_reg <= 1'b0;
            onoff_reg       <= {SINK_W{1'b0}};
            scale_r_reg     <= `LSS_SCALE_RST;
            scale_g_reg     <= `LSS_SCALE_RST;
            scale_b_reg     <= `LSS_SCALE_RST;
        end else begin
            state_reg       <= state_next;
            apply_ready_reg <= (state_next == ST_APPLY);
            // rest count loads as a word is applied and runs down to zero
            if (state_reg == ST_APPLY) begin
                rest_cnt_reg <= `LSS_REST_CYC;
            end else if (rest_cnt_reg != 3'h0) begin
                rest_cnt_reg <= rest_cnt_reg - 3'h1;
            end
            if (state_reg == ST_APPLY) begin
                if (!fifo_out_data[`LSS_SEL_BIT]) begin
                    onoff_reg <= fifo_out_data[SINK_W-1:0];
                end else begin
                    // control word: three scale fields, red lowest
                    scale_r_reg <= fifo_out_data[SCALE_W-1:0];
                    scale_g_reg <= fifo_out_data[2*SCALE_W-1:SCALE_W];
                    scale_b_reg <= fifo_out_data[3*SCALE_W-1:2*SCALE_W];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output gating: interleaved bit order, blanking overrides
    reg [GROUP_W-1:0] red_next;
    reg [GROUP_W-1:0] green_next;
    reg [GROUP_W-1:0] blue_next;
    integer           k;

    always @* begin
        red_next   = {GROUP_W{1'b0}};
        green_next = {GROUP_W{1'b0}};
        blue_next  = {GROUP_W{1'b0}};
        for (k = 0; k < GROUP_W; k = k + 1) begin
            red_next[k]   = onoff_reg[3*k]   && !blank_s;
            green_next[k] = onoff_reg[3*k+1] && !blank_s;
            blue_next[k]  = onoff_reg[3*k+2] && !blank_s;
        end
    end

    // registered outputs; scale values are registered alongside the sinks
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            red_sinks     <= {GROUP_W{1'b0}};
            green_sinks   <= {GROUP_W{1'b0}};
            blue_sinks    <= {GROUP_W{1'b0}};
            red_scale     <= `LSS_SCALE_RST;
            green_scale   <= `LSS_SCALE_RST;
            blue_scale    <= `LSS_SCALE_RST;
            latch_overrun <= 1'b0;
        end else begin
            red_sinks     <= red_next;
            green_sinks   <= green_next;
            blue_sinks    <= blue_next;
            red_scale     <= scale_r_reg;
            green_scale   <= scale_g_reg;
            blue_scale    <= scale_b_reg;
            latch_overrun <= stb_rise && !fifo_in_ready;
        end
    end
endmodule
`default_nettype wire

// ===== test/lss_ctl_model.sv
// controller model driving the serial link pins
`timescale 1ns/1ps
`default_nettype none
module lss_ctl_model (
    // clock
    input  wire logic core_clk,
    // link pins
    output var logic  shift_clk,
    output var logic  serial_in_line,
    output var logic  latch_strobe
);
    int half = 4; // half link period in core cycles
    initial begin
        shift_clk = 1'b0;
        serial_in_line = 1'b0;
        latch_strobe = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // whole word msb first, data changed while the clock is low
    task automatic send(input logic [24:0] w);
        for (int i = 24; i >= 0; i--) begin
            @(negedge core_clk);
            shift_clk = 1'b0;
            serial_in_line = w[i];
            repeat (half) @(negedge core_clk);
            shift_clk = 1'b1;
            repeat (half - 1) @(negedge core_clk);
        end
        @(negedge core_clk);
        shift_clk = 1'b0; // clock rests between frames
        serial_in_line = ~w[0]; // no stale bit on a released line
    endtask
    ////////////////////////////////////////////////////////////////
    // latch pin level and one pulse
    task automatic hold(input logic v);
        @(negedge core_clk);
        latch_strobe = v;
    endtask
    task automatic latch();
        hold(1'b1);
        repeat (half) @(negedge core_clk);
        hold(1'b0);
        repeat (half) @(negedge core_clk);
    endtask
endmodule
`default_nettype wire

// ===== test/lss_top_monitor.sv
// assertions on the pins of the sink shift and latch block
`timescale 1ns/1ps
`default_nettype none
module lss_top_monitor #(
    parameter SHIFT_W = 25,
    parameter GROUP_W = 8,
    parameter SCALE_W = 7
) (
    // clock, reset and link pins
    input wire logic               core_clk,
    input wire logic               rstn,
    input wire logic               shift_clk,
    input wire logic               serial_in_line,
    input wire logic               latch_strobe,
    input wire logic               blank_in,
    // outputs
    input wire logic               serial_out_line,
    input wire logic [GROUP_W-1:0] red_sinks,
    input wire logic [GROUP_W-1:0] green_sinks,
    input wire logic [GROUP_W-1:0] blue_sinks,
    input wire logic [SCALE_W-1:0] red_scale,
    input wire logic [SCALE_W-1:0] green_scale,
    input wire logic [SCALE_W-1:0] blue_scale,
    input wire logic               latch_overrun
);
    wire [3*GROUP_W-1:0] sinks = {blue_sinks, green_sinks, red_sinks};
    logic [5:0]          stb_age_reg;
    ////////////////////////////////////////////////////////////////
    // cycles since the latch pin was last seen high, saturating
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) stb_age_reg <= 6'h3f;
        else if (latch_strobe) stb_age_reg <= 6'h00;
        else if (stb_age_reg != 6'h3f) stb_age_reg <= stb_age_reg + 6'h01;
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence blank_held; blank_in [*2]; endsequence
    sequence shift_idle; !shift_clk [*8]; endsequence
    reset_values_a: assert property ($rose(rstn) |-> sinks == 0 && red_scale == 7'h7f)
        else $error("outputs wrong after reset");
    blank_force_a: assert property (blank_held |-> ##2 sinks == 0)
        else $error("sinks on while blanked");
    sink_cause_a: assert property ($changed(sinks) |->
        stb_age_reg < 6'd40 || $past(blank_in, 3) != $past(blank_in, 4))
        else $error("sinks changed without cause");
    scale_cause_a: assert property ($changed({red_scale, green_scale, blue_scale}) |->
        stb_age_reg < 6'd40)
        else $error("scale changed without latch");
    serial_out_line_cause_a: assert property ($changed(serial_out_line) |-> $past(shift_clk, 2))
        else $error("serial out moved without shift");
    serial_out_line_idle_a: assert property (shift_idle |-> $stable(serial_out_line))
        else $error("serial out moved while idle");
    overrun_pulse_a: assert property (latch_overrun |=> !latch_overrun)
        else $error("overrun longer than a cycle");
    overrun_cause_a: assert property (latch_overrun |-> stb_age_reg < 6'd12)
        else $error("overrun without strobe");
endmodule
bind lss_top lss_top_monitor #(.SHIFT_W(SHIFT_W), .GROUP_W(GROUP_W), .SCALE_W(SCALE_W)) u_mon (
    .core_clk, .rstn, .shift_clk, .serial_in_line, .latch_strobe, .blank_in,
    .serial_out_line, .red_sinks, .green_sinks, .blue_sinks,
    .red_scale, .green_scale, .blue_scale, .latch_overrun);
`default_nettype wire

// ===== test/lss_top_tb.sv
// self-checking bench for the sink shift and latch block
`timescale 1ns/1ps
`default_nettype none
module lss_top_tb;
    logic        core_clk = 1'b0;
    logic        rstn     = 1'b0;
    logic        blank_in = 1'b1;
    wire         shift_clk, serial_in_line, latch_strobe, serial_out_line, latch_overrun;
    wire  [7:0]  red_sinks, green_sinks, blue_sinks;
    wire  [6:0]  red_scale, green_scale, blue_scale;
    wire  [23:0] sinks = {blue_sinks, green_sinks, red_sinks};
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          n_ovr = 0;
    // word shifted in, then expected sinks blue green red
    logic [48:0] rows [7] = '{{25'h0000001, 24'h000001}, {25'h0000002, 24'h000100},
        {25'h0000004, 24'h010000}, {25'h0800000, 24'h800000}, {25'h0000000, 24'h000000},
        {25'h0492492, 24'h00ff00}, {25'h0249249, 24'h0000ff}};
    always #12.5 core_clk = ~core_clk;
    lss_top u_dut (.core_clk, .rstn, .shift_clk, .serial_in_line, .latch_strobe,
        .blank_in, .serial_out_line, .red_sinks, .green_sinks, .blue_sinks,
        .red_scale, .green_scale, .blue_scale, .latch_overrun);
    lss_ctl_model u_ctl (.core_clk, .shift_clk, .serial_in_line, .latch_strobe);
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic load(input logic [24:0] w);
        u_ctl.send(w);
        u_ctl.latch();
        repeat (12) @(negedge core_clk);
    endtask
    ////////////////////////////////////////////////////////////////
    // main sequence: reset, table rows, then awkward cases
    initial begin
        repeat (6) @(negedge core_clk);
        rstn = 1'b1;
        repeat (4) @(negedge core_clk);
        check(sinks, 0);
        check({red_scale, green_scale, blue_scale}, {3{7'h7f}});
        load(25'h0ffffff);
        check(sinks, 0);
        blank_in = 1'b0;
        repeat (5) @(negedge core_clk);
        check(sinks, 24'hffffff);
        foreach (rows[i]) begin
            u_ctl.half = (i == 2) ? 8 : 4; // one slow controller row
            load(rows[i][48:24]);
            check(sinks, rows[i][23:0]);
            check(serial_out_line, rows[i][48]);
        end
        load(25'h1159a12);
        check({red_scale, green_scale, blue_scale}, {7'h12, 7'h34, 7'h56});
        check(serial_out_line, 1'b1);
        check(sinks, 24'h0000ff);
        u_ctl.hold(1'b1);
        u_ctl.send(25'h0000001);
        repeat (12) @(negedge core_clk);
        check(sinks, 24'h0000ff);
        u_ctl.hold(1'b0);
        repeat (4) @(negedge core_clk);
        u_ctl.latch();
        repeat (12) @(negedge core_clk);
        check(sinks, 24'h000001);
        blank_in = 1'b1;
        repeat (5) @(negedge core_clk);
        check(sinks, 0);
        blank_in = 1'b0;
        repeat (5) @(negedge core_clk);
        check(sinks, 24'h000001);
        check(latch_overrun, 1'b0);
        // strobe train one cycle high, one low: faster than the latch drain
        for (int j = 0; j < 40; j++) begin
            u_ctl.hold(j[0] == 1'b0);
            n_ovr += latch_overrun;
        end
        check(n_ovr != 0, 1'b1);
        load(25'h0000002);
        check(sinks, 24'h000100);
        check(latch_overrun, 1'b0);
        rstn = 1'b0;
        repeat (2) @(negedge core_clk);
        check({sinks, red_scale}, {24'h0, 7'h7f});
        rstn = 1'b1;
        repeat (4) @(negedge core_clk);
        check({sinks, blue_scale}, {24'h0, 7'h7f});
        report_and_stop();
    end
    // watchdog well beyond the expected run length
    initial begin
        repeat (40000) @(posedge core_clk);
        n_mismatch++;
        report_and_stop();
    end
endmodule
`default_nettype wire
